/* pkg/lde_params.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  listener data, end-of-string and clock configuration block.
  Assumes inclusion by bare name from the top-level core file.
*/
`ifndef LDE_PARAMS_SVH
`define LDE_PARAMS_SVH

// Register offsets on the plain register port
`define LDE_OFF_RX_DATA   3'h0
`define LDE_OFF_TX_DATA   3'h1
`define LDE_OFF_TERM      3'h2
`define LDE_OFF_CLK_CFG   3'h3
`define LDE_OFF_CTRL      3'h4
`define LDE_OFF_STATUS    3'h5
`define LDE_OFF_IRQ_MASK  3'h6
`define LDE_OFF_AUX_CMD   3'h7

// Control register fields
`define LDE_CTRL_DMA_EN   0
`define LDE_CTRL_LREQ_EN  1
`define LDE_CTRL_BIN      2
`define LDE_CTRL_RECEIVE_TERMINATOR_ENABLE     3
`define LDE_CTRL_TRANSMIT_TERMINATOR_ENABLE     4
`define LDE_CTRL_RANGE    5
`define LDE_CTRL_CONT     6
`define LDE_CTRL_KEEP_HO  7

// Status and mask fields
`define LDE_ST_DATA_IN    0
`define LDE_ST_BYTE_IN    1
`define LDE_ST_END        2
`define LDE_ST_HOLDOFF    3
`define LDE_ST_XFER_REQ   4

// Auxiliary command fields
`define LDE_AUX_RELEASE   0

// Reset values
`define LDE_CLK_CFG_RST   8'h25
`define LDE_CTRL_RST      8'h00
`define LDE_MASK_RST      8'h00
`define LDE_BYTE_RST      8'h00

// Frequency code field of the clock configuration and tick counter width
`define LDE_FREQ_MSB      3
`define LDE_CNT_W         5

`endif

/* pkg/lde_pkg.sv */
/*
  Types shared by the listener data block, the talker model and the bench.
  Assumes the params header sits on the include path.
*/
package lde_pkg;
  // One bus data byte
  typedef logic [7:0] lde_byte_t;

  // Register offsets on the register port
  typedef enum logic [2:0] {
    LDE_REG_RX_DATA  = 3'b000,
    LDE_REG_TX_DATA  = 3'b001,
    LDE_REG_TERM     = 3'b010,
    LDE_REG_CLK_CFG  = 3'b011,
    LDE_REG_CTRL     = 3'b100,
    LDE_REG_STATUS   = 3'b101,
    LDE_REG_IRQ_MASK = 3'b110,
    LDE_REG_AUX_CMD  = 3'b111
  } lde_addr_t;
endpackage

/* core/lde_term_match.sv */
/*
  Terminator byte comparator, seven or eight bits wide.
  Assumes a purely combinational use; the parent registers the result.
*/
module lde_term_match #(
  parameter int W = 8                  // Byte width
) (
  input  wire logic [W-1:0] data_i,    // Byte under test
  input  wire logic [W-1:0] term_i,    // Terminator byte
  input  wire logic         full_i,    // High compares all bits
  output logic              match_o    // Byte equals terminator
);
  // Low bits always compared, top bit only in full mode
  always_comb begin
    match_o = (data_i[W-2:0] == term_i[W-2:0]) &&
              (!full_i || (data_i[W-1] == term_i[W-1]));
  end
endmodule

/* core/lde_top.sv */
/*
  Listener receive latch, end-of-string detector, transmit latch,
  clock configuration with microsecond tick, and status interrupt.
  Assumes listener/talker state and accept-data come in synchronous to
  clk_sys from the handshake logic, and a one-cycle register port.
*/
// Design decisions made here: the register addresses and the plain strobed port.
// Contract
// - Latch bus data while listening and accepting
// - Latching a byte sets data-in flag
// - Latching a byte places ready-for-data holdoff outside continuous mode
// - Reading receive latch may release holdoff
// - Reading receive latch drops transfer request, mostly
// - Transmit and receive latches stay separate
// - Compare seven or eight bits by mode
// - Listener match with enable sets END
// - Talker match with enable asserts EOI low
// - Clock configuration resets to 00100101
// - Frequency code and range set delays
// - Byte-in set only outside continuous mode
// - Listener DMA request while latch holds byte
`include "lde_params.svh"

module lde_top #(
  parameter int CNT_W = `LDE_CNT_W        // Tick counter width
) (
  input  wire logic             clk_sys,         // System clock
  input  wire logic             rstn,            // Sync reset, low
  input  wire logic [2:0]       addr,            // Register offset
  input  wire lde_pkg::lde_byte_t wdata,         // Write data
  input  wire logic             wr_en,           // Write strobe
  input  wire logic             rd_en,           // Read strobe
  output lde_pkg::lde_byte_t    rdata,           // Read data
  input  wire lde_pkg::lde_byte_t bus_data_in,   // Bus data lines
  input  wire logic             listener_active, // Listener state
  input  wire logic             accept_data,     // Accept-data state
  input  wire logic             talker_active,   // Talker state
  output lde_pkg::lde_byte_t    bus_data_out,    // Transmit latch
  output logic                  eoi_n_o,         // EOI pin level
  output logic                  eoi_oe,          // EOI pin drive
  output logic                  rfd_holdoff,     // Holdoff active
  output logic                  xfer_req_n,      // Transfer request
  output logic                  irq,             // Interrupt level
  output logic                  us_tick          // Delay time base
);
  import lde_pkg::*;

  // Register state
  lde_byte_t rx_data_q, rx_data_d;     // Receive latch
  lde_byte_t tx_data_q, tx_data_d;     // Transmit latch
  lde_byte_t term_q, term_d;           // Terminator byte
  lde_byte_t clk_cfg_q, clk_cfg_d;     // Clock configuration
  lde_byte_t ctrl_q, ctrl_d;           // Control bits
  lde_byte_t mask_q, mask_d;           // Interrupt mask
  logic      din_q, din_d;             // Data-in flag
  logic      bin_q, bin_d;             // Byte-in flag
  logic      end_q, end_d;             // END flag
  logic      ho_q, ho_d;               // Ready-for-data holdoff
  logic      req_q, req_d;             // Transfer request active
  logic      req_n_q, req_n_d;         // Request pin level, low asserts
  logic      cap_prev_q;               // Last capture condition
  lde_byte_t rdata_q, rdata_d;         // Read data register
  logic      eoi_q, eoi_d;             // EOI asserted
  logic      eoi_n_q, eoi_n_d;         // EOI pin level, low asserts
  logic      irq_q, irq_d;             // Interrupt output
  logic [CNT_W-1:0] cnt_q, cnt_d;      // Tick counter
  logic      tick_q, tick_d;           // Tick output

  // Decoded strobes and conditions
  logic      cap;                      // New byte accepted
  logic      rd_rx, wr_tx, wr_st;      // Register actions
  logic      rx_match, tx_match;       // Terminator matches
  logic      dma_en, lreq_en;          // DMA controls
  logic      cont, keep_ho;            // Listener modes
  logic [CNT_W-1:0] period;            // Cycles per tick
  lde_byte_t status;                   // Assembled status

  // Capture on the first cycle of listener accept-data
  assign cap     = listener_active && accept_data && !cap_prev_q;
  assign rd_rx   = rd_en && (addr == `LDE_OFF_RX_DATA);
  assign wr_tx   = wr_en && (addr == `LDE_OFF_TX_DATA);
  assign wr_st   = wr_en && (addr == `LDE_OFF_STATUS);
  assign dma_en  = ctrl_q[`LDE_CTRL_DMA_EN];
  assign lreq_en = ctrl_q[`LDE_CTRL_LREQ_EN];
  assign cont    = ctrl_q[`LDE_CTRL_CONT];
  assign keep_ho = ctrl_q[`LDE_CTRL_KEEP_HO];

  // Comparator for incoming bus bytes
  lde_term_match #(.W(8)) u_rx_match (
    .data_i  (bus_data_in),
    .term_i  (term_q),
    .full_i  (ctrl_q[`LDE_CTRL_BIN]),
    .match_o (rx_match)
  );

  // Comparator for the outgoing byte
  lde_term_match #(.W(8)) u_tx_match (
    .data_i  (tx_data_q),
    .term_i  (term_q),
    .full_i  (ctrl_q[`LDE_CTRL_BIN]),
    .match_o (tx_match)
  );

  // Status word as seen by software
  always_comb begin
    status = 8'h00;
    status[`LDE_ST_DATA_IN]  = din_q;
    status[`LDE_ST_BYTE_IN]  = bin_q;
    status[`LDE_ST_END]      = end_q;
    status[`LDE_ST_HOLDOFF]  = ho_q;
    status[`LDE_ST_XFER_REQ] = req_q;
  end

  // Configuration registers written by software
  always_comb begin
    tx_data_d = tx_data_q;
    term_d    = term_q;
    clk_cfg_d = clk_cfg_q;
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    if (wr_en) begin
      unique case (addr)
        `LDE_OFF_TX_DATA:  tx_data_d = wdata;
        `LDE_OFF_TERM:     term_d    = wdata;
        // Upper nibble kept as written; software supplies 0010
        `LDE_OFF_CLK_CFG:  clk_cfg_d = wdata;
        `LDE_OFF_CTRL:     ctrl_d    = wdata;
        `LDE_OFF_IRQ_MASK: mask_d    = wdata;
        default:           ;
      endcase
    end
  end

  // Receive latch follows the bus only on capture
  always_comb begin
    rx_data_d = rx_data_q;
    if (cap) begin
      rx_data_d = bus_data_in;
    end
  end

  // Sticky flags: set beats a same-cycle clear
  always_comb begin
    din_d = din_q;
    bin_d = bin_q;
    end_d = end_q;
    // Write one to clear
    if (wr_st) begin
      din_d = din_q && !wdata[`LDE_ST_DATA_IN];
      bin_d = bin_q && !wdata[`LDE_ST_BYTE_IN];
      end_d = end_q && !wdata[`LDE_ST_END];
    end
    // Host read of the latch retires byte-in
    if (rd_rx) begin
      din_d = 1'b0;
      bin_d = 1'b0;
    end
    if (cap) begin
      din_d = 1'b1;
      if (!cont) begin
        bin_d = 1'b1;
      end
      if (ctrl_q[`LDE_CTRL_RECEIVE_TERMINATOR_ENABLE] && rx_match) begin
        end_d = 1'b1;
      end
    end
  end

  // Holdoff and DMA request for the listener path
  always_comb begin
    ho_d  = ho_q;
    req_d = req_q;
    // Read releases holdoff unless software keeps it
    if (rd_rx && !keep_ho) begin
      ho_d = 1'b0;
    end
    if (wr_en && (addr == `LDE_OFF_AUX_CMD) &&
        wdata[`LDE_AUX_RELEASE]) begin
      ho_d = 1'b0;
    end
    // Read drops the request except DMA on, listener request off
    if (rd_rx && !(dma_en && !lreq_en)) begin
      req_d = 1'b0;
    end
    if (cap) begin
      if (!cont) begin
        ho_d = 1'b1;
      end
      if (dma_en && lreq_en) begin
        req_d = 1'b1;
      end
    end
    // Request only stands while listening
    if (!listener_active) begin
      req_d = 1'b0;
    end
    // Pin level kept in its own flop so the pin has no inverter
    req_n_d = !req_d;
  end

  // Read data, one cycle after the strobe; write-only reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `LDE_OFF_RX_DATA:  rdata_d = rx_data_q;
        `LDE_OFF_CTRL:     rdata_d = ctrl_q;
        `LDE_OFF_STATUS:   rdata_d = status;
        `LDE_OFF_IRQ_MASK: rdata_d = mask_q;
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // Talker end-of-string and interrupt outputs
  always_comb begin
    eoi_d = talker_active && ctrl_q[`LDE_CTRL_TRANSMIT_TERMINATOR_ENABLE] && tx_match;
    eoi_n_d = !eoi_d;
    irq_d = |({3'b000, req_d, ho_d, end_d, bin_d, din_d} & mask_d);
  end

  // Tick period: frequency code, doubled in the high range
  always_comb begin
    period = CNT_W'(clk_cfg_q[`LDE_FREQ_MSB:0]) <<
             ctrl_q[`LDE_CTRL_RANGE];
    if (period == '0) begin
      period = CNT_W'(1);
    end
    cnt_d  = cnt_q + CNT_W'(1);
    tick_d = 1'b0;
    if (cnt_q >= period - CNT_W'(1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rx_data_q  <= `LDE_BYTE_RST;
      tx_data_q  <= `LDE_BYTE_RST;
      term_q     <= `LDE_BYTE_RST;
      clk_cfg_q  <= `LDE_CLK_CFG_RST;
      ctrl_q     <= `LDE_CTRL_RST;
      mask_q     <= `LDE_MASK_RST;
      din_q      <= 1'b0;
      bin_q      <= 1'b0;
      end_q      <= 1'b0;
      ho_q       <= 1'b0;
      req_q      <= 1'b0;
      req_n_q    <= 1'b1;
      cap_prev_q <= 1'b0;
      rdata_q    <= 8'h00;
      eoi_q      <= 1'b0;
      eoi_n_q    <= 1'b1;
      irq_q      <= 1'b0;
      cnt_q      <= '0;
      tick_q     <= 1'b0;
    end else begin
      rx_data_q  <= rx_data_d;
      tx_data_q  <= tx_data_d;
      term_q     <= term_d;
      clk_cfg_q  <= clk_cfg_d;
      ctrl_q     <= ctrl_d;
      mask_q     <= mask_d;
      din_q      <= din_d;
      bin_q      <= bin_d;
      end_q      <= end_d;
      ho_q       <= ho_d;
      req_q      <= req_d;
      req_n_q    <= req_n_d;
      cap_prev_q <= listener_active && accept_data;
      rdata_q    <= rdata_d;
      eoi_q      <= eoi_d;
      eoi_n_q    <= eoi_n_d;
      irq_q      <= irq_d;
      cnt_q      <= cnt_d;
      tick_q     <= tick_d;
    end
  end

  // Outputs straight from flops
  assign rdata        = rdata_q;
  assign bus_data_out = tx_data_q;
  assign eoi_n_o      = eoi_n_q;
  assign eoi_oe       = eoi_q;
  assign rfd_holdoff  = ho_q;
  assign xfer_req_n   = req_n_q;
  assign irq          = irq_q;
  assign us_tick      = tick_q;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Cycles since the last tick; only intervals free of config writes
  logic [CNT_W:0] gap_q;
  logic           gap_ok_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn || tick_q) begin
      gap_q <= '0;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + (CNT_W+1)'(1);
    end
    if (!rstn || (wr_en && (addr == `LDE_OFF_CLK_CFG ||
                            addr == `LDE_OFF_CTRL))) begin
      gap_ok_q <= 1'b0;
    end else if (tick_q) begin
      gap_ok_q <= 1'b1;
    end
  end

  a_latch_bus_data: assert property (
    cap |=> rx_data_q == $past(bus_data_in))
    else $error("Receive latch missed bus byte");
  a_din_on_capture: assert property (
    cap |=> din_q && rdata_q == $past(rdata_d))
    else $error("Data-in flag not set on capture");
  a_holdoff_set: assert property (
    cap && !cont |=> rfd_holdoff ##1
      (rfd_holdoff || $past(rd_rx || wr_en)))
    else $error("Holdoff missing after capture");
  a_read_clears_bi: assert property (
    rd_rx && !cap |=> !bin_q)
    else $error("Byte-in survived latch read");
  a_read_releases: assert property (
    rd_rx && !keep_ho && !cap && !(wr_en) |=> !rfd_holdoff)
    else $error("Holdoff not released by read");
  a_req_drop_read: assert property (
    rd_rx && !cap && !(dma_en && !lreq_en) |=> xfer_req_n)
    else $error("Transfer request kept after read");
  a_tx_keeps_rx: assert property (
    wr_tx && !cap |=> $stable(rx_data_q))
    else $error("Transmit write disturbed receive latch");
  a_end_on_match: assert property (
    cap && ctrl_q[`LDE_CTRL_RECEIVE_TERMINATOR_ENABLE] && rx_match |=> end_q)
    else $error("END flag not set on terminator");
  a_eoi_on_match: assert property (
    talker_active && ctrl_q[`LDE_CTRL_TRANSMIT_TERMINATOR_ENABLE] && tx_match
      |=> !eoi_n_o && eoi_oe)
    else $error("EOI not asserted with terminator");
  a_cfg_reset_val: assert property (
    $past(!rstn) |-> clk_cfg_q == `LDE_CLK_CFG_RST)
    else $error("Clock configuration reset value wrong");
  a_tick_period: assert property (
    tick_q && gap_ok_q |-> gap_q == {1'b0, period} - 1'b1)
    else $error("Tick period does not follow code");
  a_bi_cont_mode: assert property (
    cap && cont && !bin_q |=> !bin_q)
    else $error("Byte-in set in continuous mode");
  a_req_on_capture: assert property (
    cap && dma_en && lreq_en |=> !xfer_req_n)
    else $error("Listener DMA request not raised");

  c_capture: cover property (cap ##1 rd_rx);
  c_end_seen: cover property (cap && rx_match && ctrl_q[`LDE_CTRL_RECEIVE_TERMINATOR_ENABLE]);
  c_eoi_sent: cover property (eoi_oe);
  c_irq_raised: cover property (!irq ##1 irq);
endmodule

/* verification/lde_bus_talker.sv */
/*
  Far-side talker model: waits while the block holds off, then puts
  a byte on the data lines and shows accept-data for one cycle.
  Assumes clk_sys and rstn from the bench, holdoff from the block.
*/
module lde_bus_talker (
  input  wire logic               clk_sys,  // System clock
  input  wire logic               rstn,     // Sync reset, low
  input  wire logic               send,     // Start one byte
  input  wire lde_pkg::lde_byte_t byte_i,   // Byte to send
  input  wire logic               holdoff,  // Block holds off
  output lde_pkg::lde_byte_t      bus_data, // Data lines
  output logic                    accept,   // Accept-data state
  output logic                    done      // Byte handed over
);
  timeunit 1ns;
  timeprecision 1ns;
  import lde_pkg::*;
  logic [1:0] st_q;   // Transfer phase
  lde_byte_t  hold_q; // Byte in flight

  // Present, accept, release; released lines show the inverse byte
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    if (!rstn) begin
      st_q     <= 2'h0;
      accept   <= 1'b0;
      bus_data <= 8'hFF;
      hold_q   <= 8'h00;
    end else begin
      case (st_q)
        2'h0: if (send) begin
          hold_q <= byte_i;
          st_q   <= 2'h1;
        end
        2'h1: if (!holdoff) begin
          bus_data <= hold_q;
          st_q     <= 2'h2;
        end
        2'h2: begin
          accept <= 1'b1;
          st_q   <= 2'h3;
        end
        default: begin
          accept   <= 1'b0;
          bus_data <= ~hold_q;
          done     <= 1'b1;
          st_q     <= 2'h0;
        end
      endcase
    end
  end
endmodule

/* verification/lde_top_tb_top.sv */
/*
  Self-checking bench of the listener data block: register port
  tasks, a far-side talker model, one task per scenario.
  Assumes the package and the params header are compiled first.
*/
module lde_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lde_pkg::*;
  logic       clk_sys, rstn, wr_en, rd_en, send;  // Clock and strobes
  logic       listener_active, talker_active;     // Bus states
  logic       accept_data, done, eoi_n_o, eoi_oe; // Handshake, EOI
  logic       rfd_holdoff, xfer_req_n, irq;       // Flags
  logic       us_tick;                            // Time base
  logic [2:0] addr;                               // Register offset
  lde_byte_t  wdata, rdata, bus_data_in;          // Data paths
  lde_byte_t  bus_data_out, tx_byte;              // Latch, far byte
  int         err_total, tests_run;               // Tallies

  lde_top dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .bus_data_in(bus_data_in), .listener_active(listener_active),
    .accept_data(accept_data), .talker_active(talker_active),
    .bus_data_out(bus_data_out), .eoi_n_o(eoi_n_o), .eoi_oe(eoi_oe),
    .rfd_holdoff(rfd_holdoff), .xfer_req_n(xfer_req_n), .irq(irq),
    .us_tick(us_tick));
  lde_bus_talker far (.clk_sys(clk_sys), .rstn(rstn), .send(send),
    .byte_i(tx_byte), .holdoff(rfd_holdoff), .bus_data(bus_data_in),
    .accept(accept_data), .done(done));

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("Mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One comparison
  task automatic chk(input lde_byte_t got, input lde_byte_t exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Let one edge land
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [2:0] a, input lde_byte_t d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Register read, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output lde_byte_t d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Read and compare
  task automatic rc(input logic [2:0] a, input lde_byte_t e,
                    input string m);
    lde_byte_t v;
    rd(a, v);
    chk(v, e, m);
  endtask
  // Far side hands over one byte, bounded wait
  task automatic put(input lde_byte_t b);
    int n;
    @(posedge clk_sys);
    tx_byte <= b;
    send    <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      settle();
      n++;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t byte never accepted", $time);
      tally_and_finish();
    end
    settle();
  endtask
  // Cycles between two time base pulses
  task automatic gap(output int n);
    n = 0;
    while (us_tick !== 1'b1 && n < 200) begin
      settle();
      n++;
    end
    n = 0;
    do begin
      settle();
      n++;
    end while (us_tick !== 1'b1 && n < 200);
    if (us_tick !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t time base stalled", $time);
      tally_and_finish();
    end
  endtask

  // Reset state and default clock code
  task automatic s_reset;
    int n;
    chk({4'h0, xfer_req_n, irq, eoi_n_o, rfd_holdoff}, 8'h0A, "rst");
    rc(LDE_REG_STATUS, 8'h00, "status rst");
    rc(LDE_REG_CLK_CFG, 8'h00, "cfg reads 0");
    gap(n);
    gap(n);
    chk(n[7:0], 8'h05, "tick 5");
  endtask
  // Code with range bit sets the delay base
  task automatic s_clock;
    int n;
    wr(LDE_REG_CTRL, 8'h20);
    wr(LDE_REG_CLK_CFG, 8'h25);
    gap(n);
    gap(n);
    chk(n[7:0], 8'h0A, "tick range");
    wr(LDE_REG_CTRL, 8'h00);
    wr(LDE_REG_CLK_CFG, 8'h28);
    gap(n);
    gap(n);
    chk(n[7:0], 8'h08, "tick 8");
  endtask
  // Capture, flags, interrupt, request, separate latches, read
  task automatic s_capture;
    wr(LDE_REG_CTRL, 8'h03);
    wr(LDE_REG_IRQ_MASK, 8'h01);
    put(8'hA5);
    rc(LDE_REG_STATUS, 8'h1B, "flags");
    chk({6'h0, rfd_holdoff, xfer_req_n}, 8'h02, "hold req");
    chk({7'h0, irq}, 8'h01, "irq set");
    wr(LDE_REG_IRQ_MASK, 8'h00);
    settle();
    chk({7'h0, irq}, 8'h00, "irq masked");
    wr(LDE_REG_TX_DATA, 8'h3C);
    settle();
    chk(bus_data_out, 8'h3C, "tx latch");
    rc(LDE_REG_RX_DATA, 8'hA5, "rx data");
    rc(LDE_REG_STATUS, 8'h00, "after read");
    chk({6'h0, rfd_holdoff, xfer_req_n}, 8'h01, "released");
    wr(LDE_REG_IRQ_MASK, 8'h01);
    put(8'h5E);
    chk({7'h0, irq}, 8'h01, "irq again");
    wr(LDE_REG_STATUS, 8'h01);
    settle();
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rc(LDE_REG_RX_DATA, 8'h5E, "rx second");
  endtask
  // Terminator match, seven and eight bits
  task automatic s_eos;
    wr(LDE_REG_CTRL, 8'h08);
    wr(LDE_REG_TERM, 8'h8A);
    put(8'h0A);
    rc(LDE_REG_STATUS, 8'h0F, "end 7bit");
    rc(LDE_REG_RX_DATA, 8'h0A, "rx eos");
    rc(LDE_REG_STATUS, 8'h04, "end sticky");
    wr(LDE_REG_STATUS, 8'h04);
    wr(LDE_REG_CTRL, 8'h0C);
    put(8'h0A);
    rc(LDE_REG_STATUS, 8'h0B, "no end 8bit");
    rc(LDE_REG_RX_DATA, 8'h0A, "rx bin");
    put(8'h8A);
    rc(LDE_REG_STATUS, 8'h0F, "end 8bit");
    rc(LDE_REG_RX_DATA, 8'h8A, "rx bin2");
    wr(LDE_REG_STATUS, 8'h04);
  endtask
  // Continuous mode: no byte-in, no holdoff
  task automatic s_cont;
    wr(LDE_REG_CTRL, 8'h40);
    put(8'h77);
    rc(LDE_REG_STATUS, 8'h01, "continuous");
    rc(LDE_REG_RX_DATA, 8'h77, "rx cont");
  endtask
  // Kept holdoff, command release, request kept, then dropped
  task automatic s_hold;
    wr(LDE_REG_CTRL, 8'h83);
    put(8'h12);
    wr(LDE_REG_CTRL, 8'h81);
    rc(LDE_REG_RX_DATA, 8'h12, "rx kept");
    chk({6'h0, rfd_holdoff, xfer_req_n}, 8'h02, "kept");
    wr(LDE_REG_AUX_CMD, 8'h01);
    settle();
    chk({7'h0, rfd_holdoff}, 8'h00, "aux release");
    @(posedge clk_sys);
    listener_active <= 1'b0;
    settle();
    chk({7'h0, xfer_req_n}, 8'h01, "req unlisten");
  endtask
  // Talker sends EOI with a matching byte
  task automatic s_eoi;
    @(posedge clk_sys);
    listener_active <= 1'b0;
    talker_active   <= 1'b1;
    wr(LDE_REG_CTRL, 8'h10);
    wr(LDE_REG_TERM, 8'h41);
    wr(LDE_REG_TX_DATA, 8'hC1);
    settle();
    chk({6'h0, eoi_n_o, eoi_oe}, 8'h01, "eoi 7bit");
    wr(LDE_REG_TX_DATA, 8'h42);
    settle();
    chk({6'h0, eoi_n_o, eoi_oe}, 8'h02, "eoi off");
  endtask

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    rstn            = 1'b0;
    wr_en           = 1'b0;
    rd_en           = 1'b0;
    send            = 1'b0;
    addr            = 3'h0;
    wdata           = 8'h00;
    tx_byte         = 8'h00;
    listener_active = 1'b1;
    talker_active   = 1'b0;
    err_total       = 0;
    tests_run       = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    s_reset();
    s_clock();
    s_capture();
    s_eos();
    s_cont();
    s_hold();
    s_eoi();
    tally_and_finish();
  end
endmodule
